//--- otgcev_link.sv
// Purpose: link-side model issuing register accesses
// Assumes: one access per call, strobe held for one cycle
// Notes: write data is inverted once released, so a stale value never looks valid
`timescale 1ns/1ps
module otgcev_link
  import otgcev_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  output logic [5:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead
);
  initial
  begin
    regAddr = 6'h3f;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // reserved otg bit 0 is always sent as zero
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= (a inside {OTG_CTRL_WR, OTG_CTRL_SET, OTG_CTRL_CLR}) ? {d[7:1], 1'b0} : d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regWrData <= ~regWrData;
    @(negedge core_clk);
  endtask
  // data is taken at the edge where valid is seen
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
    d = regRdValid ? regRdData : 8'hxx;
  endtask
endmodule

//--- otgcev_pkg.sv
// Purpose: shared constants and types for the otg_power_and_pull_control and event enable bank
// Assumes: 6-bit immediate register addresses, 8-bit register data
// Notes: every offset, field position and reset value lives here
package otgcev_pkg;

  // ---------------------------------------------------------------
  // register addresses (write / set / clear, read at write address)
  // ---------------------------------------------------------------
  localparam logic [5:0] OTG_CTRL_WR = 6'h0a; // otg power and pull control
  localparam logic [5:0] OTG_CTRL_SET = 6'h0b;
  localparam logic [5:0] OTG_CTRL_CLR = 6'h0c;
  localparam logic [5:0] RISE_EN_WR = 6'h0d; // event rise enable
  localparam logic [5:0] RISE_EN_SET = 6'h0e;
  localparam logic [5:0] RISE_EN_CLR = 6'h0f;
  localparam logic [5:0] FALL_EN_WR = 6'h10; // event fall enable
  localparam logic [5:0] FALL_EN_SET = 6'h11;
  localparam logic [5:0] FALL_EN_CLR = 6'h12;
  localparam logic [5:0] EVT_STATUS_RD = 6'h13; // current source levels
  localparam logic [5:0] EVT_LATCH_RD = 6'h14; // sticky event latch

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OTG_CTRL_RST = 8'h06; // both pull-downs connected
  localparam logic [7:0] EDGE_EN_RST = 8'h1f; // every edge enabled
  localparam logic [7:0] READ_ZERO = 8'h00; // unmapped read answer

  // ---------------------------------------------------------------
  // otg_power_and_pull_control field positions
  // ---------------------------------------------------------------
  localparam int OTG_EXT_IND_SEL = 7; // external_indicator_select
  localparam int OTG_EXT_SUPPLY = 6; // external_supply_drive
  localparam int OTG_BUS_DRIVE = 5; // bus_power_drive
  localparam int OTG_BUS_CHARGE = 4; // bus_power_charge
  localparam int OTG_BUS_DISCHARGE = 3; // bus_power_discharge
  localparam int OTG_MINUS_PD = 2; // minus_line_pulldown
  localparam int OTG_PLUS_PD = 1; // plus_line_pulldown

  // ---------------------------------------------------------------
  // event sources; bit order matches the enable and latch bytes
  // ---------------------------------------------------------------
  localparam int SRC_COUNT = 4;
  localparam int SYNC_DEPTH = 3; // pin synchroniser stages
  typedef struct packed {
    logic sessionFinished; // bit 3
    logic sessionOk; // bit 2
    logic busPowerOk; // bit 1
    logic hostUnplug; // bit 0
  } otgcev_src_s;

  // register access kinds decoded from the address
  typedef enum {
    OTGCEV_OP_WRITE,
    OTGCEV_OP_SET,
    OTGCEV_OP_CLEAR
  } otgcev_op_e;

endpackage

//--- otgcev_regs.sv
// Purpose: otg_power_and_pull_control byte and rising / falling event enable bytes of a ulpi phy
// Assumes: register port driven by the link-side logic on core_clk; comparator and fault
//          levels arrive asynchronously from analog circuitry
// Notes: read data appears one cycle after the read strobe; latch clears on read
`timescale 1ns/1ps

// Functional notes
// - bit 7 picks internal or external indicator
// - bit 6 drives power switch pin low
// - bit 4 charges bus power via resistor
// - bit 3 discharges bus power via resistor
// - bit 2 connects minus line pull-down
// - bit 1 connects plus line pull-down
// - enabled rising edge raises interrupt and rxcmd
// - enabled falling edge raises interrupt and rxcmd
// - rise enable bits 3..0 map four sources
// - fall enable uses the same bit map
// - both enable bytes reset to 1f
// - otg_power_and_pull_control at 0a, 0b, 0c
// - enables at 0d..0f and 10..12
// - latch sets on edge, clears on read/low-power
module otgcev_regs
  import otgcev_pkg::*;
#(
  parameter int SYNC_STAGES = SYNC_DEPTH
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic sessionFinishedCmp,
  input wire logic sessionOkCmp,
  input wire logic busPowerOkCmp,
  input wire logic hostUnplugDetect,
  input wire logic faultIn,
  input wire logic lowPowerEnter,
  output logic powerSwitchOut,
  output logic powerSwitchOeN,
  output logic busPowerDrive,
  output logic externalSupplyDrive,
  output logic busPowerCharge,
  output logic busPowerDischarge,
  output logic minusLinePulldown,
  output logic plusLinePulldown,
  output logic externalIndicatorSelect,
  output otgcev_src_s eventLevels,
  output logic eventIrq,
  output logic rxcmdRequest
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (SYNC_STAGES != 3)
  begin : g_badSync
    $error("SYNC_STAGES must be 3: the filter compares stages two and three");
  end

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // apply a write, set or clear access to one byte
  function automatic logic [7:0] applyAccess(input logic [7:0] old, input logic [7:0] data,
                                             input otgcev_op_e op);
    logic [7:0] result;
    result = old;
    case (op)
      OTGCEV_OP_WRITE: result = data;
      OTGCEV_OP_SET: result = old | data;
      OTGCEV_OP_CLEAR: result = old & ~data;
      default: result = old;
    endcase
    return result;
  endfunction

  // decode an address against a write/set/clear triple
  function automatic logic hitTriple(input logic [5:0] addr, input logic [5:0] base);
    return (addr == base) || (addr == base + 6'h01) || (addr == base + 6'h02);
  endfunction

  // turn an offset within a triple into an access kind
  function automatic otgcev_op_e opOf(input logic [5:0] addr, input logic [5:0] base);
    otgcev_op_e op;
    op = OTGCEV_OP_WRITE;
    if (addr == base + 6'h01)
    begin
      op = OTGCEV_OP_SET;
    end
    else if (addr == base + 6'h02)
    begin
      op = OTGCEV_OP_CLEAR;
    end
    return op;
  endfunction

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] otgPowerAndPullControl; // otg_power_and_pull_control byte
  logic [7:0] eventRiseEnable; // rising edge enables
  logic [7:0] eventFallEnable; // falling edge enables
  logic [3:0] eventLatch; // sticky edge record
  logic [3:0] srcSync1; // first stage, read only by stage two
  logic [3:0] srcSync2;
  logic [3:0] srcSync3;
  logic faultSync1; // first stage, read only by stage two
  logic faultSync2;
  logic faultSync3;
  logic [3:0] srcFiltered; // agreed comparator levels
  logic faultFiltered; // agreed fault level
  logic [3:0] srcPrev; // source level one cycle ago

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire hitOtg = hitTriple(regAddr, OTG_CTRL_WR);
  wire hitRise = hitTriple(regAddr, RISE_EN_WR);
  wire hitFall = hitTriple(regAddr, FALL_EN_WR);
  wire hitStatus = (regAddr == EVT_STATUS_RD);
  wire hitLatch = (regAddr == EVT_LATCH_RD);
  wire [7:0] next_otgCtrl = applyAccess(otgPowerAndPullControl, regWrData, opOf(regAddr, OTG_CTRL_WR));
  wire [7:0] next_riseEn = applyAccess(eventRiseEnable, regWrData, opOf(regAddr, RISE_EN_WR));
  wire [7:0] next_fallEn = applyAccess(eventFallEnable, regWrData, opOf(regAddr, FALL_EN_WR));

  // ---------------------------------------------------------------
  // event source selection and edge detection
  // ---------------------------------------------------------------
  wire extSel = otgPowerAndPullControl[OTG_EXT_IND_SEL];
  // bus power ok comes from the fault pin when the external indicator is chosen
  wire busOkSrc = extSel ? faultFiltered : srcFiltered[1];
  wire [3:0] srcNow = {srcFiltered[3:2], busOkSrc, srcFiltered[0]};
  wire [3:0] riseEdge = srcNow & ~srcPrev;
  wire [3:0] fallEdge = ~srcNow & srcPrev;
  wire [3:0] riseHit = riseEdge & eventRiseEnable[3:0];
  wire [3:0] fallHit = fallEdge & eventFallEnable[3:0];
  wire [3:0] edgeHit = riseHit | fallHit;
  wire latchReadClear = (regRead && hitLatch) || lowPowerEnter;

  // read data selection; unmapped addresses and the upper status and latch bits read zero
  wire [7:0] readMux = hitOtg ? otgPowerAndPullControl :
                       hitRise ? eventRiseEnable :
                       hitFall ? eventFallEnable :
                       hitStatus ? {4'h0, srcNow} :
                       hitLatch ? {4'h0, eventLatch} : READ_ZERO;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // three stages for every asynchronous level
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      srcSync1 <= 4'h0;
      srcSync2 <= 4'h0;
      srcSync3 <= 4'h0;
      faultSync1 <= 1'b0;
      faultSync2 <= 1'b0;
      faultSync3 <= 1'b0;
    end
    else
    begin
      srcSync1 <= {sessionFinishedCmp, sessionOkCmp, busPowerOkCmp, hostUnplugDetect};
      srcSync2 <= srcSync1;
      srcSync3 <= srcSync2;
      faultSync1 <= faultIn;
      faultSync2 <= faultSync1;
      faultSync3 <= faultSync2;
    end
  end

  // a level change counts only once stages two and three agree;
  // this costs a cycle but stops a metastable settle from making a false edge
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      srcFiltered <= 4'h0;
      faultFiltered <= 1'b0;
    end
    else
    begin
      srcFiltered <= (srcSync2 & srcSync3) | (srcFiltered & (srcSync2 ^ srcSync3));
      if (faultSync2 == faultSync3)
      begin
        faultFiltered <= faultSync3;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // otg_power_and_pull_control byte; reserved bit 0 is stored as written
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      otgPowerAndPullControl <= OTG_CTRL_RST;
    end
    else if (regWrite && hitOtg)
    begin
      otgPowerAndPullControl <= next_otgCtrl;
    end
  end

  // edge enable bytes, both reset to every edge enabled
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eventRiseEnable <= EDGE_EN_RST;
      eventFallEnable <= EDGE_EN_RST;
    end
    else
    begin
      if (regWrite && hitRise)
      begin
        eventRiseEnable <= next_riseEn;
      end
      if (regWrite && hitFall)
      begin
        eventFallEnable <= next_fallEn;
      end
    end
  end

  // ---------------------------------------------------------------
  // event tracking and latch
  // ---------------------------------------------------------------
  // previous level; starts at zero so a source high at reset counts as a rise
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      srcPrev <= 4'h0;
    end
    else
    begin
      srcPrev <= srcNow;
    end
  end

  // sticky latch; a new edge in the clearing cycle survives the clear
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eventLatch <= 4'h0;
    end
    else if (latchReadClear)
    begin
      eventLatch <= edgeHit;
    end
    else
    begin
      eventLatch <= eventLatch | edgeHit;
    end
  end

  // one-cycle interrupt and rxcmd request per enabled edge cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eventIrq <= 1'b0;
      rxcmdRequest <= 1'b0;
      eventLevels <= '0;
    end
    else
    begin
      eventIrq <= |edgeHit;
      rxcmdRequest <= |edgeHit;
      eventLevels <= srcNow; // level carried in the rxcmd byte
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // read answer registered, one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regRdData <= READ_ZERO;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRead;
      if (regRead)
      begin
        regRdData <= readMux;
      end
    end
  end

  // ---------------------------------------------------------------
  // analog and pin controls
  // ---------------------------------------------------------------
  // open-drain switch: drive low when enabled, otherwise release the pin
  assign powerSwitchOut = 1'b0;
  assign powerSwitchOeN = ~otgPowerAndPullControl[OTG_EXT_SUPPLY];
  // the link may rely on the external supply alone and leave this clear
  assign busPowerDrive = otgPowerAndPullControl[OTG_BUS_DRIVE];
  assign externalSupplyDrive = otgPowerAndPullControl[OTG_EXT_SUPPLY];
  // charge and discharge are not interlocked; sequencing is the link's job
  assign busPowerCharge = otgPowerAndPullControl[OTG_BUS_CHARGE];
  assign busPowerDischarge = otgPowerAndPullControl[OTG_BUS_DISCHARGE];
  assign minusLinePulldown = otgPowerAndPullControl[OTG_MINUS_PD];
  assign plusLinePulldown = otgPowerAndPullControl[OTG_PLUS_PD];
  assign externalIndicatorSelect = extSel;

endmodule

//--- otgcev_regs_bench.sv
// Purpose: self-checking bench for the otg_power_and_pull_control and edge enable bank
// Assumes: 25 MHz core_clk, link model issues all accesses
// Notes: event windows allow for the synchroniser and filter delay
`timescale 1ns/1ps
module otgcev_regs_bench
  import otgcev_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData, rdv;
  logic regWrite, regRead, regRdValid, powerSwitchOut, powerSwitchOeN, busPowerDrive;
  logic externalSupplyDrive, busPowerCharge, busPowerDischarge, minusLinePulldown;
  logic plusLinePulldown, externalIndicatorSelect, eventIrq, rxcmdRequest;
  logic faultIn = 1'b0;
  logic lowPowerEnter = 1'b0;
  logic [3:0] src = 4'h0; // comparator levels, same bit order as enables
  otgcev_src_s eventLevels;
  wire [7:0] ctlv = {externalIndicatorSelect, externalSupplyDrive, busPowerDrive, busPowerCharge,
    busPowerDischarge, minusLinePulldown, plusLinePulldown, 1'b0};
  int mismatches = 0;
  int cmp_count = 0;
  always #20 core_clk = ~core_clk;
  otgcev_regs uut (.core_clk, .rst_b, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .regRdValid, .sessionFinishedCmp(src[3]), .sessionOkCmp(src[2]), .busPowerOkCmp(src[1]),
    .hostUnplugDetect(src[0]), .faultIn, .lowPowerEnter, .powerSwitchOut, .powerSwitchOeN,
    .busPowerDrive, .externalSupplyDrive, .busPowerCharge, .busPowerDischarge, .minusLinePulldown,
    .plusLinePulldown, .externalIndicatorSelect, .eventLevels, .eventIrq, .rxcmdRequest);
  otgcev_link link (.core_clk, .regRdData, .regRdValid, .regAddr, .regWrData, .regWrite, .regRead);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    link.rd(a, rdv);
    chk("read data", exp, rdv);
  endtask
  // drive fault and sources, then count irq pulses over the filter window
  task automatic pulses(input logic [4:0] lv, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge core_clk);
    {faultIn, src} <= lv;
    repeat (12)
    begin
      @(posedge core_clk);
      n += (eventIrq === 1'b1);
    end
    chk("irq pulses", exp, n[7:0]);
  endtask
  task automatic t_reset;
    chk("controls", 8'h06, ctlv);
    chk("switch oe", 8'h01, {7'h0, powerSwitchOeN});
    rdchk(OTG_CTRL_WR, 8'h06);
    rdchk(RISE_EN_WR, 8'h1f);
    rdchk(FALL_EN_WR, 8'h1f);
    $display("test reset done");
  endtask
  // one control bit at a time; discharge comes before charge, and the data lines are not modelled,
  // so the SE0 time before charging is taken as already checked by the link
  task automatic t_ctrl;
    logic [7:0] d;
    for (int b = 1; b < 8; b++)
    begin
      d = 8'h01 << b;
      link.wr(OTG_CTRL_WR, d);
      chk("controls", d, ctlv);
      chk("switch oe", {7'h0, ~d[6]}, {7'h0, powerSwitchOeN});
      rdchk(OTG_CTRL_WR, d);
      // discharge stays on until session end rises and its interrupt is seen;
      // session end then stays high so the charge write finds the bus discharged
      if (b == 3)
      begin
        pulses(5'h08, 8'h01);
      end
    end
    // drop session end again; both of its edges are enabled, one latch bit
    pulses(5'h00, 8'h01);
    rdchk(EVT_LATCH_RD, 8'h08);
    $display("test control done");
  endtask
  task automatic t_setclr;
    logic [5:0] base [3] = '{OTG_CTRL_WR, RISE_EN_WR, FALL_EN_WR};
    foreach (base[i])
    begin
      link.wr(base[i], 8'h20);
      link.wr(base[i] + 6'h1, 8'h44);
      rdchk(base[i] + 6'h1, 8'h64);
      link.wr(base[i] + 6'h2, 8'h24);
      rdchk(base[i] + 6'h2, 8'h40);
    end
    link.wr(6'h20, 8'hff);
    rdchk(6'h20, 8'h00);
    link.wr(OTG_CTRL_WR, 8'h06);
    $display("test set clear done");
  endtask
  // all sources move together, so only the enabled bit may latch
  task automatic t_edges;
    logic [7:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = 8'h01 << i;
      link.wr(RISE_EN_WR, m);
      link.wr(FALL_EN_WR, 8'h00);
      pulses(5'h0f, 8'h01);
      chk("levels", 8'h0f, {4'h0, eventLevels});
      rdchk(EVT_STATUS_RD, 8'h0f);
      rdchk(EVT_LATCH_RD, m);
      rdchk(EVT_LATCH_RD, 8'h00);
      pulses(5'h00, 8'h00);
      link.wr(RISE_EN_WR, 8'h00);
      link.wr(FALL_EN_WR, m);
      pulses(5'h0f, 8'h00);
      pulses(5'h00, 8'h01);
      rdchk(EVT_LATCH_RD, m);
    end
    $display("test edges done");
  endtask
  // external indicator replaces the bus power comparator
  task automatic t_ind;
    link.wr(OTG_CTRL_WR, 8'h80);
    link.wr(RISE_EN_WR, 8'h02);
    pulses(5'h10, 8'h01);
    // status shows the indicator pin in place of the idle comparator
    rdchk(EVT_STATUS_RD, 8'h02);
    pulses(5'h12, 8'h00);
    @(posedge core_clk);
    lowPowerEnter <= 1'b1;
    @(posedge core_clk);
    lowPowerEnter <= 1'b0;
    rdchk(EVT_LATCH_RD, 8'h00);
    $display("test indicator done");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    t_reset;
    t_ctrl;
    t_setclr;
    t_edges;
    t_ind;
    summarize;
  end
  // watchdog: the whole run needs well under 2000 cycles
  initial
  begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule
bind otgcev_regs otgcev_regs_chk chk_i (.core_clk, .rst_b, .regAddr, .regWrData, .regWrite, .regRead,
  .regRdData, .regRdValid, .powerSwitchOut, .powerSwitchOeN, .busPowerDrive, .externalSupplyDrive,
  .busPowerCharge, .busPowerDischarge, .minusLinePulldown, .plusLinePulldown, .externalIndicatorSelect,
  .eventLevels, .eventIrq, .rxcmdRequest);

//--- otgcev_regs_chk.sv
// Purpose: port assertions for the otg_power_and_pull_control and edge enable bank
// Assumes: one clock domain, reset active low
// Notes: control pins are viewed as one vector matching byte bits 7..1
`timescale 1ns/1ps
module otgcev_regs_chk
  import otgcev_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic powerSwitchOut,
  input wire logic powerSwitchOeN,
  input wire logic busPowerDrive,
  input wire logic externalSupplyDrive,
  input wire logic busPowerCharge,
  input wire logic busPowerDischarge,
  input wire logic minusLinePulldown,
  input wire logic plusLinePulldown,
  input wire logic externalIndicatorSelect,
  input wire otgcev_src_s eventLevels,
  input wire logic eventIrq,
  input wire logic rxcmdRequest
);
  // --------
  // helpers
  // --------
  logic [6:0] ctl;
  logic wrOtg;
  logic setOtg;
  logic clrOtg;
  assign ctl = {externalIndicatorSelect, externalSupplyDrive, busPowerDrive, busPowerCharge,
    busPowerDischarge, minusLinePulldown, plusLinePulldown};
  assign wrOtg = regWrite && regAddr == OTG_CTRL_WR;
  assign setOtg = regWrite && regAddr == OTG_CTRL_SET;
  assign clrOtg = regWrite && regAddr == OTG_CTRL_CLR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_switch_pin_low: assert property (powerSwitchOeN == !externalSupplyDrive && !powerSwitchOut)
    else $error("power switch pin disagrees with control");
  a_ctrl_write_lands: assert property (wrOtg |=> ctl == $past(regWrData[7:1]))
    else $error("control write not applied");
  a_ctrl_set_ors: assert property (setOtg |=> ctl == ($past(ctl) | $past(regWrData[7:1])))
    else $error("control set wrong");
  a_ctrl_clear_ands: assert property (clrOtg |=> ctl == ($past(ctl) & ~$past(regWrData[7:1])))
    else $error("control clear wrong");
  a_ctrl_holds: assert property (!(wrOtg || setOtg || clrOtg) |=> $stable(ctl))
    else $error("control changed without access");
  a_ctrl_readback: assert property (regRead && regAddr == OTG_CTRL_WR |=> regRdData[7:1] == $past(ctl))
    else $error("control read data wrong");
  a_read_valid_pulse: assert property (1'b1 |=> regRdValid == $past(regRead))
    else $error("read valid timing wrong");
  a_irq_rxcmd_same: assert property (eventIrq == rxcmdRequest)
    else $error("irq and rxcmd differ");
  a_irq_has_edge: assert property (eventIrq |-> eventLevels != $past(eventLevels))
    else $error("irq without level change");
  c_irq: cover property (eventIrq);
  c_set: cover property (setOtg);
  c_read: cover property (regRdValid);
endmodule
